//--- tdm_link_ring.sv
package tdm_ring_pkg;
	localparam int LINKS = 16;
	localparam int REFS = 4;
	localparam int SEL_W = 5;
	localparam int CNT_W = 10;
	localparam int CLK_NS = 25;
	localparam int FRAME_RATE_HZ = 8000;
	localparam logic [1:0] SIZE_32 = 2'h0;
	localparam logic [1:0] SIZE_64 = 2'h1;
	localparam logic [1:0] SIZE_128 = 2'h2;
	localparam int RING_DEPTH = 2;

	typedef struct packed {
		logic frame_start;
		logic [3:0] link;
		logic [7:0] data;
	} rx_word_type;

	typedef enum {RING_IDLE, RING_HEAD, RING_DATA} ring_state_type;

	// Last bit index of a frame for a channel count
	function automatic logic [CNT_W-1:0] frame_last(input logic [1:0] size);
		unique case (size)
			SIZE_32: frame_last = 10'h0FF;
			SIZE_64: frame_last = 10'h1FF;
			default: frame_last = 10'h3FF;
		endcase
	endfunction

	function automatic logic frame_seen(input logic level, input logic telecom, input logic pol);
		frame_seen = telecom ? !level : (level == pol);
	endfunction
endpackage

`timescale 1ns/100ps
module tdm_link_ring import tdm_ring_pkg::*; (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [LINKS-1:0] serial_rx_data,
	input wire logic [LINKS-1:0] link_rx_clock,
	input wire logic [LINKS-1:0] link_rx_frame_pulse,
	input wire logic [REFS-1:0] ref_clock_in,
	input wire logic [LINKS-1:0] link_tx_clock_in,
	output logic [LINKS-1:0] link_tx_clock_out,
	output logic [LINKS-1:0] link_tx_clock_oe,
	input wire logic [LINKS-1:0] link_tx_frame_pulse_in,
	output logic [LINKS-1:0] link_tx_frame_pulse_out,
	output logic [LINKS-1:0] link_tx_frame_pulse_oe,
	output logic [LINKS-1:0] serial_tx_data,
	output logic [LINKS-1:0] serial_tx_data_oe,
	input wire logic [LINKS-1:0] link_enable,
	input wire logic [LINKS-1:0] telecom_mode,
	input wire logic [LINKS-1:0] rx_frame_polarity,
	input wire logic [LINKS-1:0] tx_frame_polarity,
	input wire logic [LINKS-1:0][1:0] rx_frame_size,
	input wire logic [LINKS-1:0][1:0] tx_frame_size,
	input wire logic [LINKS-1:0] tx_clock_output,
	input wire logic [LINKS-1:0] tx_clock_invert,
	input wire logic [LINKS-1:0][SEL_W-1:0] tx_clock_select,
	input wire logic [LINKS-1:0] tx_frame_output,
	input wire logic [LINKS-1:0] tx_slot_active,
	input wire logic [LINKS-1:0] tx_bit_data,
	input wire logic ring_enable,
	output logic [LINKS-1:0] rx_overrun,
	output logic [LINKS-1:0] rx_frame_lost,
	output logic ring_out_clock,
	output logic ring_out_sync,
	output logic [7:0] ring_out_bus,
	output logic ring_out_oe
);
	logic [LINKS-1:0] rxc_m_q, rxc_s_q, rxc_p_q, rxd_m_q, rxd_s_q, rxf_m_q, rxf_s_q;
	logic [LINKS-1:0] txc_m_q, txc_s_q, txf_m_q, txf_s_q, teff_q;
	logic [REFS-1:0] ref_m_q, ref_s_q;
	logic [LINKS-1:0] rx_rise, rx_frame, tx_edge, teff, pend_q, pend_sof_q, grant;
	logic [LINKS-1:0][7:0] shift_q, pend_data_q;
	logic [LINKS-1:0][CNT_W-1:0] rxcnt_q, txcnt_q;
	logic [LINKS-1:0] src_clk;
	rx_word_type in_word, out_word;
	logic in_valid, in_ready, out_valid, out_ready, ring_ph_q;
	ring_state_type ring_state_q;

	// Two flops per pin feed logic from the second stage; the receive clocks get a third flop for rising-edge detection
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			{rxc_m_q, rxc_s_q, rxc_p_q, rxd_m_q, rxd_s_q, rxf_m_q, rxf_s_q} <= '0;
			{txc_m_q, txc_s_q, txf_m_q, txf_s_q, ref_m_q, ref_s_q} <= '0;
		end else begin
			rxc_m_q <= link_rx_clock;
			rxc_s_q <= rxc_m_q;
			rxc_p_q <= rxc_s_q;
			rxd_m_q <= serial_rx_data;
			rxd_s_q <= rxd_m_q;
			rxf_m_q <= link_rx_frame_pulse;
			rxf_s_q <= rxf_m_q;
			txc_m_q <= link_tx_clock_in;
			txc_s_q <= txc_m_q;
			txf_m_q <= link_tx_frame_pulse_in;
			txf_s_q <= txf_m_q;
			ref_m_q <= ref_clock_in;
			ref_s_q <= ref_m_q;
		end
	end

	always_comb begin
		for (int i = 0; i < LINKS; i++) begin
			rx_rise[i] = rxc_s_q[i] && !rxc_p_q[i];
			rx_frame[i] = frame_seen(rxf_s_q[i], telecom_mode[i], rx_frame_polarity[i]);
			src_clk[i] = tx_clock_select[i][4] ? ref_s_q[tx_clock_select[i][1:0]]
				: rxc_s_q[tx_clock_select[i][3:0]];
			teff[i] = (tx_clock_output[i] ? src_clk[i] : txc_s_q[i]) ^ tx_clock_invert[i];
			tx_edge[i] = teff[i] && !teff_q[i];
		end
	end

	// Receive: count bits from the frame pulse, hand over each byte
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rxcnt_q <= '0;
			shift_q <= '0;
			pend_q <= '0;
			pend_sof_q <= '0;
			pend_data_q <= '0;
			rx_overrun <= '0;
			rx_frame_lost <= '0;
		end else begin
			for (int i = 0; i < LINKS; i++) begin
				if (grant[i]) begin
					pend_q[i] <= 1'b0;
				end
				if (rx_rise[i] && link_enable[i]) begin
					logic [CNT_W-1:0] cnt;
					logic [7:0] sh;
					cnt = '0;
					sh = {shift_q[i][6:0], rxd_s_q[i]};
					if (rx_frame[i]) begin
						rx_frame_lost[i] <= 1'b0;
					end else if (rxcnt_q[i] == frame_last(rx_frame_size[i])) begin
						rx_frame_lost[i] <= 1'b1;
					end else begin
						cnt = rxcnt_q[i] + 1'b1;
					end
					shift_q[i] <= sh;
					rxcnt_q[i] <= cnt;
					if (cnt[2:0] == 3'h7) begin
						// A new byte wins over the grant that clears the slot
						pend_q[i] <= 1'b1;
						pend_data_q[i] <= sh;
						pend_sof_q[i] <= (cnt == 10'h007);
						if (pend_q[i] && !grant[i]) begin
							rx_overrun[i] <= 1'b1;
						end
					end
				end
			end
		end
	end

	// Fixed priority to the lowest link; a byte lasts eight link bits, far longer than a scan
	always_comb begin
		grant = '0;
		in_word = '0;
		in_valid = 1'b0;
		for (int i = LINKS - 1; i >= 0; i--) begin
			if (pend_q[i]) begin
				in_valid = 1'b1;
				in_word = '{frame_start: pend_sof_q[i], link: 4'(i), data: pend_data_q[i]};
				grant = '0;
				grant[i] = in_ready;
			end
		end
	end

	tdm_ring_fifo2 #(.WIDTH($bits(rx_word_type)), .DEPTH(RING_DEPTH)) buffer_u (
		.mclk(mclk),
		.reset_n(reset_n),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data(in_word),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_word)
	);

	// Transmit clock, frame pulse and data per link
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			teff_q <= '0;
			txcnt_q <= '0;
			link_tx_clock_out <= '0;
			link_tx_clock_oe <= '0;
			link_tx_frame_pulse_out <= '1;
			link_tx_frame_pulse_oe <= '0;
			serial_tx_data <= '0;
			serial_tx_data_oe <= '0;
		end else begin
			teff_q <= teff;
			for (int i = 0; i < LINKS; i++) begin
				link_tx_clock_out[i] <= src_clk[i] ^ tx_clock_invert[i];
				link_tx_clock_oe[i] <= tx_clock_output[i];
				link_tx_frame_pulse_oe[i] <= tx_frame_output[i];
				link_tx_frame_pulse_out[i] <= telecom_mode[i] ? (txcnt_q[i] != '0)
					: ((txcnt_q[i] == '0) == tx_frame_polarity[i]);
				if (tx_edge[i]) begin
					if (!tx_frame_output[i]
						&& frame_seen(txf_s_q[i], telecom_mode[i], tx_frame_polarity[i])) begin
						txcnt_q[i] <= '0;
					end else if (txcnt_q[i] == frame_last(tx_frame_size[i])) begin
						txcnt_q[i] <= '0;
					end else begin
						txcnt_q[i] <= txcnt_q[i] + 1'b1;
					end
					serial_tx_data[i] <= tx_bit_data[i];
					serial_tx_data_oe[i] <= link_enable[i] && tx_slot_active[i];
				end
				if (!link_enable[i]) begin
					serial_tx_data_oe[i] <= 1'b0;
				end
			end
		end
	end

	// Ring port: clock is mclk halved; a sync byte carries frame start and link, then the data
	assign out_ready = ring_ph_q && (ring_state_q == RING_HEAD);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ring_ph_q <= 1'b0;
			ring_out_clock <= 1'b0;
			ring_out_oe <= 1'b0;
			ring_out_sync <= 1'b0;
			ring_out_bus <= '0;
			ring_state_q <= RING_IDLE;
		end else begin
			ring_ph_q <= ring_enable && !ring_ph_q;
			ring_out_clock <= ring_enable && !ring_ph_q;
			ring_out_oe <= ring_enable;
			if (ring_ph_q) begin
				unique case (ring_state_q)
					RING_HEAD: begin
						ring_out_bus <= out_word.data;
						ring_out_sync <= 1'b0;
						ring_state_q <= RING_DATA;
					end
					RING_IDLE, RING_DATA: begin
						ring_out_sync <= out_valid;
						ring_out_bus <= out_valid ? {out_word.frame_start, 3'h0, out_word.link} : '0;
						ring_state_q <= out_valid ? RING_HEAD : RING_IDLE;
					end
				endcase
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence head_s;
		$rose(ring_out_sync);
	endsequence
	sequence data_s;
		##2 !ring_out_sync;
	endsequence

	ring_idle_hiz_a: assert property (!ring_enable |=> !ring_out_oe && !ring_out_clock)
		else $error("ring driven while unused");
	ring_pair_a: assert property (head_s |-> data_s)
		else $error("ring sync not followed by data byte");
	ring_clock_a: assert property (ring_out_oe && $past(ring_out_oe) |-> ring_out_clock != $past(ring_out_clock))
		else $error("ring clock stalled");
	tx_unused_hiz_a: assert property (!link_enable[0] |=> !serial_tx_data_oe[0])
		else $error("unused link data driven");
	tx_clock_dir_a: assert property (tx_clock_output[0] |=> link_tx_clock_oe[0] && link_tx_clock_out[0] == $past(src_clk[0] ^ tx_clock_invert[0]))
		else $error("tx clock output wrong");
	tx_telecom_fp_a: assert property (telecom_mode[0] |=> link_tx_frame_pulse_out[0] == ($past(txcnt_q[0]) != '0))
		else $error("telecom frame pulse wrong");
	tx_generic_fp_a: assert property (!telecom_mode[0] |=> link_tx_frame_pulse_out[0] == (($past(txcnt_q[0]) == '0) == $past(tx_frame_polarity[0])))
		else $error("generic frame pulse polarity wrong");
	rx_capture_a: assert property ($rose(pend_q[0]) |-> $past(rx_rise[0]))
		else $error("byte without receive clock edge");
	rx_frame_clear_a: assert property (rx_rise[0] && link_enable[0] && rx_frame[0] |=> !rx_frame_lost[0] && rxcnt_q[0] == '0)
		else $error("frame pulse did not realign");
endmodule

//--- tdm_ring_fifo2.sv
`timescale 1ns/100ps
module tdm_ring_fifo2 #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 2
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign in_ready = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Head word is read straight from a storage register
	assign out_data = mem_q[rd_q];

	always_ff @(posedge mclk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//--- tdm_framer_model.sv
`timescale 1ns/100ps
module tdm_framer_model import tdm_ring_pkg::*; #(
	parameter int HALF_NS = 100
) (
	input wire logic run,
	input wire logic pulse_level,
	input wire logic [7:0] first_byte,
	output logic [LINKS-1:0] link_rx_clock,
	output logic [LINKS-1:0] link_rx_frame_pulse,
	output logic [LINKS-1:0] serial_rx_data
);
	logic rx_clk = 1'b0;
	int bit_q = 0;
	initial begin
		link_rx_frame_pulse = '1;
		serial_rx_data = '0;
	end
	always #(HALF_NS) rx_clk = ~rx_clk;
	assign link_rx_clock = {LINKS{rx_clk}};
	// Launch on the falling edge so bits are steady at the sampling rise
	always @(negedge rx_clk) begin
		if (!run) begin
			bit_q <= 0;
			link_rx_frame_pulse <= {LINKS{!pulse_level}};
			serial_rx_data <= '0;
		end else begin
			link_rx_frame_pulse <= {LINKS{(bit_q == 0) ? pulse_level : !pulse_level}};
			serial_rx_data <= {LINKS{(bit_q < 8) ? first_byte[7 - bit_q] : 1'b0}};
			bit_q <= (bit_q == 255) ? 0 : bit_q + 1;
		end
	end
endmodule

//--- tdm_link_ring_tb.sv
`timescale 1ns/100ps
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
	$display("wrong value %s expected %h seen %h", what, exp, got); end end
module tdm_link_ring_tb import tdm_ring_pkg::*;;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [REFS-1:0] ref_clock_in = '0;
	logic [LINKS-1:0] link_tx_clock_in = '0, link_tx_frame_pulse_in = '0, link_enable = '0;
	logic [LINKS-1:0] telecom_mode = '0, rx_frame_polarity = '0, tx_frame_polarity = '0;
	logic [LINKS-1:0][1:0] rx_frame_size = '0, tx_frame_size = '0;
	logic [LINKS-1:0] tx_clock_output = '0, tx_clock_invert = '0, tx_frame_output = '0;
	logic [LINKS-1:0][SEL_W-1:0] tx_clock_select = '0;
	logic [LINKS-1:0] tx_slot_active = '0, tx_bit_data = '0, link_rx_clock, link_rx_frame_pulse;
	logic [LINKS-1:0] serial_rx_data, link_tx_clock_out, link_tx_clock_oe, rx_overrun, rx_frame_lost;
	logic [LINKS-1:0] link_tx_frame_pulse_out, link_tx_frame_pulse_oe, serial_tx_data, serial_tx_data_oe;
	logic ring_enable = 1'b0, ring_out_clock, ring_out_sync, ring_out_oe, run = 1'b0, pulse_level = 1'b1;
	logic [7:0] ring_out_bus, first_byte = 8'h00;
	int seed = 32'hAA45, error_cnt = 0, samples_checked = 0;

	always #12.5 mclk = ~mclk;

	tdm_framer_model i_tdm_framer_model (.run(run), .pulse_level(pulse_level),
		.first_byte(first_byte), .link_rx_clock(link_rx_clock),
		.link_rx_frame_pulse(link_rx_frame_pulse), .serial_rx_data(serial_rx_data));

	tdm_link_ring i_tdm_link_ring (.*);

	function automatic logic [LINKS-1:0] tx_clk_expect(input logic [REFS-1:0] r, input logic [LINKS-1:0] v);
		for (int k = 0; k < LINKS; k++) begin
			tx_clk_expect[k] = r[k % REFS] ^ v[k];
		end
	endfunction

	task automatic test_done();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic ring_get(output logic [7:0] ctrl, output logic [7:0] data);
		int n;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (!(ring_out_sync === 1'b1 && ring_out_bus[7] === 1'b1) && n < 3000);
		if (n >= 3000) begin
			error_cnt++;
			test_done();
		end else begin
			// Bytes change with the ring clock low, so the far end samples mid-byte
			`CHK("ring clock at byte", 1'b0, ring_out_clock)
			`CHK("ring oe", 1'b1, ring_out_oe)
			ctrl = ring_out_bus;
			repeat (2) @(negedge mclk);
			`CHK("ring sync on data", 1'b0, ring_out_sync)
			data = ring_out_bus;
		end
	endtask

	initial begin
		int lnk;
		logic [7:0] byte_v, ctrl_v, data_v;
		for (int k = 0; k < LINKS; k++) begin
			tx_clock_select[k] <= SEL_W'(16 + k % REFS);
		end
		// Clock keeps running while reset is held
		repeat (2) @(negedge mclk);
		`CHK("tx pulse in reset", {LINKS{1'b1}}, link_tx_frame_pulse_out)
		`CHK("ring oe in reset", 1'b0, ring_out_oe)
		@(posedge mclk);
		reset_n <= 1'b1;
		// Reference clocks held still long enough to cross the synchroniser
		for (int p = 0; p < 12; p++) begin
			@(posedge mclk);
			ref_clock_in <= REFS'($random(seed));
			tx_clock_invert <= (p < 8) ? LINKS'($random(seed)) : '0;
			tx_clock_output <= (p < 8) ? LINKS'($random(seed)) : '1;
			link_tx_clock_in <= LINKS'($random(seed));
			link_tx_frame_pulse_in <= LINKS'($random(seed));
			tx_frame_output <= LINKS'($random(seed));
			tx_frame_polarity <= LINKS'($random(seed));
			tx_frame_size <= (2 * LINKS)'($random(seed));
			link_enable <= LINKS'($random(seed));
			tx_slot_active <= LINKS'($random(seed));
			tx_bit_data <= LINKS'($random(seed));
			repeat (6) @(negedge mclk);
			if (p < 8) begin
				`CHK("tx clock", tx_clk_expect(ref_clock_in, tx_clock_invert), link_tx_clock_out)
				`CHK("tx clock oe", tx_clock_output, link_tx_clock_oe)
				`CHK("tx frame oe", tx_frame_output, link_tx_frame_pulse_oe)
			end else begin
				@(posedge mclk);
				ref_clock_in <= '0;
				repeat (6) @(posedge mclk);
				ref_clock_in <= '1;
				repeat (6) @(negedge mclk);
				`CHK("tx data oe", tx_slot_active & link_enable, serial_tx_data_oe)
				`CHK("tx data", tx_bit_data, serial_tx_data)
			end
		end
		`CHK("ring clock idle", 1'b0, ring_out_clock)
		`CHK("ring oe idle", 1'b0, ring_out_oe)
		@(posedge mclk);
		ring_enable <= 1'b1;
		for (int m = 0; m < 3; m++) begin
			@(posedge mclk);
			lnk = $unsigned($random(seed)) % LINKS;
			byte_v = 8'($random(seed));
			link_enable <= LINKS'(1) << lnk;
			telecom_mode <= {LINKS{m == 0}};
			rx_frame_polarity <= {LINKS{m == 2}};
			pulse_level <= (m == 2);
			first_byte <= byte_v;
			repeat (20) @(posedge mclk);
			run <= 1'b1;
			ring_get(ctrl_v, data_v);
			`CHK("ring control", {1'b1, 3'h0, 4'(lnk)}, ctrl_v)
			`CHK("ring data", byte_v, data_v)
			@(posedge mclk);
			run <= 1'b0;
		end
		// Last link stays enabled with no pulse: the frame must run out
		repeat (2200) @(posedge mclk);
		@(negedge mclk);
		`CHK("frame lost", LINKS'(1) << lnk, rx_frame_lost)
		`CHK("overrun", {LINKS{1'b0}}, rx_overrun)
		test_done();
	end
endmodule
